// ---- common/dsic_pkg.sv ----
// Shared constants and carrier types for the dual serial port block.
package dsic_pkg;

  // ****************************************************************
  // Sizes and counts
  // ****************************************************************
  localparam int          DATA_W     = 32'h0000_0010;
  localparam int          PORTS      = 32'h0000_0002;
  localparam int          DEPTH_ZERO = 32'h0000_0001;
  localparam int          DEPTH_ONE  = 32'h0000_0004;
  localparam int          BIT_CNT_W  = 32'h0000_0005;
  localparam logic [4:0]  WORD_BITS  = 5'h10;
  localparam logic [4:0]  LAST_BIT   = 5'h0F;
  localparam int          MSB        = 32'h0000_000F;

  // ****************************************************************
  // Clocking
  // ****************************************************************
  localparam int          CLK_HZ       = 32'h0131_2D00;
  localparam logic [0:0]  BUS_DIV_LAST = 1'h1;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef logic [DATA_W-1:0] dsic_word_t;

  typedef enum logic [1:0] {
    DSIC_IDLE,
    DSIC_MASTER,
    DSIC_SLAVE
  } dsic_state_e;

  typedef struct packed {
    logic sclk;
    logic ss_b;
    logic mosi;
    logic miso;
  } dsic_pin_in_s;

  typedef struct packed {
    logic sclk;
    logic sclk_oe;
    logic ss_b;
    logic ss_b_oe;
    logic mosi;
    logic mosi_oe;
    logic miso;
    logic miso_oe;
  } dsic_pin_out_s;

  localparam dsic_pin_out_s PIN_OUT_RST = 8'h20;

endpackage : dsic_pkg

// ---- rtl/dsic_fifo.sv ----
// Flip-flop FIFO with registered head word and registered flags.
`timescale 1ns/100ps
`default_nettype none

module dsic_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 4
) (
  input  wire logic             clk_in,
  input  wire logic             rst_b_in,
  input  wire logic             in_valid_in,
  input  wire logic [WIDTH-1:0] in_data_in,
  output var  logic             in_ready_out,
  output var  logic             out_valid_out,
  output var  logic [WIDTH-1:0] out_data_out,
  input  wire logic             out_ready_in
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [WIDTH-1:0] mem_d [DEPTH];
  logic [PW-1:0]    wr_q;
  logic [PW-1:0]    wr_d;
  logic [PW-1:0]    rd_q;
  logic [PW-1:0]    rd_d;
  logic [PW:0]      cnt_q;
  logic [PW:0]      cnt_d;
  logic             not_full_d;
  logic             not_empty_d;
  logic [WIDTH-1:0] head_d;
  logic             push;
  logic             pop;

  function automatic logic [PW-1:0] next_ptr(input logic [PW-1:0] p);
    if (p == PW'(DEPTH - 1))
    begin
      return '0;
    end
    return p + PW'(1);
  endfunction : next_ptr

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb
  begin
    push   = in_valid_in & in_ready_out;
    pop    = out_ready_in & out_valid_out;
    mem_d  = mem_q;
    wr_d   = wr_q;
    rd_d   = rd_q;
    cnt_d  = cnt_q;
    if (push)
    begin
      mem_d[wr_q] = in_data_in;
      wr_d        = next_ptr(wr_q);
      cnt_d       = cnt_d + (PW+1)'(1);
    end
    if (pop)
    begin
      rd_d  = next_ptr(rd_q);
      cnt_d = cnt_d - (PW+1)'(1);
    end
    not_full_d  = (cnt_d != (PW+1)'(DEPTH));
    not_empty_d = (cnt_d != '0);
    // The head is registered so that the consumer sees a flop, not a mux.
    head_d      = mem_d[rd_d];
  end

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      for (int k = 0; k < DEPTH; k++)
      begin
        mem_q[k] <= '0;
      end
      wr_q          <= '0;
      rd_q          <= '0;
      cnt_q         <= '0;
      in_ready_out  <= 1'b1;
      out_valid_out <= 1'b0;
      out_data_out  <= '0;
    end
    else
    begin
      mem_q         <= mem_d;
      wr_q          <= wr_d;
      rd_q          <= rd_d;
      cnt_q         <= cnt_d;
      in_ready_out  <= not_full_d;
      out_valid_out <= not_empty_d;
      out_data_out  <= head_d;
    end
  end

endmodule : dsic_fifo

`default_nettype wire

// ---- rtl/dsic_top.sv ----
// Two serial peripheral ports with word buffers, DMA requests and stop-mode wakeup.
`timescale 1ns/100ps
`default_nettype none

// Contract
// - Two independent serial ports, zero and one, each with its own clock rate.
// - Each port shifts words of sixteen bits.
// - Port one buffers data in four-entry, sixteen-bit queues.
// - Port zero runs from the bus clock and derives all timing from it; stop entry ends its master word on any system clock.
// - Port one runs from the system clock, not the bus clock.
// - Port one is inactive while the chip is in partial stop; only its engine freezes, its queues and DMA requests keep working.
// - Each port raises DMA requests for transmit space and received words.
// - In very low power stop a port works only as a slave.
// - A slave port in very low power stop wakes the processor on received data.
module dsic_top (
  input  wire logic                          clk_in,
  input  wire logic                          rst_b_in,
  input  wire logic                          partial_stop_in,
  input  wire logic                          very_low_power_stop_in,
  input  wire logic [1:0]                    master_mode_in,
  input  wire logic [1:0]                    tx_valid_in,
  input  wire dsic_pkg::dsic_word_t [1:0]    tx_data_in,
  output var  logic [1:0]                    tx_ready_out,
  output var  logic [1:0]                    rx_valid_out,
  output var  dsic_pkg::dsic_word_t [1:0]    rx_data_out,
  input  wire logic [1:0]                    rx_ready_in,
  output var  logic [1:0]                    dma_tx_req_out,
  output var  logic [1:0]                    dma_rx_req_out,
  output var  logic [1:0]                    busy_out,
  output var  logic [1:0]                    rx_overrun_out,
  input  wire dsic_pkg::dsic_pin_in_s [1:0]  pin_in,
  output var  dsic_pkg::dsic_pin_out_s [1:0] pin_out,
  output var  logic                          wakeup_out
);

  // ****************************************************************
  // Bus clock enable
  // ****************************************************************
  // The bus clock is half the system clock; it is a one-cycle enable.
  logic [0:0] bus_cnt_q;
  logic [0:0] bus_cnt_d;
  logic       bus_tick_q;
  logic       bus_tick_d;

  always_comb
  begin
    bus_tick_d = (bus_cnt_q == dsic_pkg::BUS_DIV_LAST);
    bus_cnt_d  = bus_tick_d ? 1'h0 : bus_cnt_q + 1'h1;
  end

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      bus_cnt_q  <= 1'h0;
      bus_tick_q <= 1'b0;
    end
    else
    begin
      bus_cnt_q  <= bus_cnt_d;
      bus_tick_q <= bus_tick_d;
    end
  end

  // ****************************************************************
  // Port instances
  // ****************************************************************
  logic [1:0] wake_evt;

  for (genvar i = 0; i < dsic_pkg::PORTS; i++)
  begin : g_port
    localparam int DEPTH = (i == 0) ? dsic_pkg::DEPTH_ZERO
                                    : dsic_pkg::DEPTH_ONE;

    logic                     tick;
    logic                     master_ok;
    logic                     txf_valid;
    dsic_pkg::dsic_word_t     txf_data;
    logic                     txf_pop;
    logic                     rxf_push;
    dsic_pkg::dsic_word_t     rxf_data;
    logic                     rxf_ready;
    logic                     rise;
    logic                     fall;
    dsic_pkg::dsic_word_t     load_word;
    dsic_pkg::dsic_state_e    state_q;
    dsic_pkg::dsic_state_e    state_d;
    dsic_pkg::dsic_word_t     sh_q;
    dsic_pkg::dsic_word_t     sh_d;
    logic [4:0]               cnt_q;
    logic [4:0]               cnt_d;
    logic                     sclk_prev_q;
    logic                     sclk_prev_d;
    dsic_pkg::dsic_pin_out_s  pins_q;
    dsic_pkg::dsic_pin_out_s  pins_d;
    logic                     busy_d;
    logic                     ovr_d;

    // Port zero steps on the bus clock enable; port one on every system
    // clock, frozen in partial stop as if its clock had been stopped.
    if (i == 0)
    begin : g_bus
      assign tick = bus_tick_q;
    end
    else
    begin : g_sys
      assign tick = ~partial_stop_in;
    end

    assign master_ok = master_mode_in[i] & ~very_low_power_stop_in;

    dsic_fifo #(
      .WIDTH (dsic_pkg::DATA_W),
      .DEPTH (DEPTH)
    ) u_tx_fifo (
      .clk_in        (clk_in),
      .rst_b_in      (rst_b_in),
      .in_valid_in   (tx_valid_in[i]),
      .in_data_in    (tx_data_in[i]),
      .in_ready_out  (tx_ready_out[i]),
      .out_valid_out (txf_valid),
      .out_data_out  (txf_data),
      .out_ready_in  (txf_pop)
    );

    dsic_fifo #(
      .WIDTH (dsic_pkg::DATA_W),
      .DEPTH (DEPTH)
    ) u_rx_fifo (
      .clk_in        (clk_in),
      .rst_b_in      (rst_b_in),
      .in_valid_in   (rxf_push),
      .in_data_in    (rxf_data),
      .in_ready_out  (rxf_ready),
      .out_valid_out (rx_valid_out[i]),
      .out_data_out  (rx_data_out[i]),
      .out_ready_in  (rx_ready_in[i])
    );

    assign dma_tx_req_out[i] = tx_ready_out[i];
    assign dma_rx_req_out[i] = rx_valid_out[i];
    assign pin_out[i]        = pins_q;

    // **************************************************************
    // Shift engine
    // **************************************************************
    always_comb
    begin
      state_d     = state_q;
      sh_d        = sh_q;
      cnt_d       = cnt_q;
      pins_d      = pins_q;
      txf_pop     = 1'b0;
      rxf_push    = 1'b0;
      rxf_data    = sh_q;
      wake_evt[i] = 1'b0;
      rise        = tick & pin_in[i].sclk & ~sclk_prev_q;
      fall        = tick & ~pin_in[i].sclk & sclk_prev_q;
      sclk_prev_d = tick ? pin_in[i].sclk : sclk_prev_q;
      // A slave with nothing queued answers with zeros.
      load_word   = txf_valid ? txf_data : '0;
      case (state_q)
        dsic_pkg::DSIC_IDLE:
        begin
          pins_d         = dsic_pkg::PIN_OUT_RST;
          pins_d.sclk_oe = master_ok;
          pins_d.ss_b_oe = master_ok;
          pins_d.mosi_oe = master_ok;
          cnt_d          = '0;
          if (tick && master_ok && txf_valid)
          begin
            txf_pop     = 1'b1;
            sh_d        = txf_data;
            pins_d.ss_b = 1'b0;
            pins_d.mosi = txf_data[dsic_pkg::MSB];
            state_d     = dsic_pkg::DSIC_MASTER;
          end
          else if (tick && !master_ok && !pin_in[i].ss_b)
          begin
            txf_pop        = txf_valid;
            sh_d           = load_word;
            pins_d.miso    = load_word[dsic_pkg::MSB];
            pins_d.miso_oe = 1'b1;
            state_d        = dsic_pkg::DSIC_SLAVE;
          end
        end
        dsic_pkg::DSIC_MASTER:
        begin
          if (!master_ok)
          begin
            // Stop entry ends a master word at once; the partial word is lost.
            pins_d.ss_b = 1'b1;
            state_d     = dsic_pkg::DSIC_IDLE;
          end
          else if (tick && !pins_q.sclk)
          begin
            sh_d        = {sh_q[dsic_pkg::MSB-1:0], pin_in[i].miso};
            cnt_d       = cnt_q + 5'h01;
            pins_d.sclk = 1'b1;
          end
          else if (tick)
          begin
            pins_d.sclk = 1'b0;
            if (cnt_q == dsic_pkg::WORD_BITS)
            begin
              rxf_push    = 1'b1;
              pins_d.ss_b = 1'b1;
              state_d     = dsic_pkg::DSIC_IDLE;
            end
            else
            begin
              pins_d.mosi = sh_q[dsic_pkg::MSB];
            end
          end
        end
        dsic_pkg::DSIC_SLAVE:
        begin
          if (tick && pin_in[i].ss_b)
          begin
            pins_d.miso_oe = 1'b0;
            state_d        = dsic_pkg::DSIC_IDLE;
          end
          else if (rise)
          begin
            sh_d  = {sh_q[dsic_pkg::MSB-1:0], pin_in[i].mosi};
            cnt_d = cnt_q + 5'h01;
            if (cnt_q == dsic_pkg::LAST_BIT)
            begin
              rxf_push    = 1'b1;
              rxf_data    = {sh_q[dsic_pkg::MSB-1:0], pin_in[i].mosi};
              wake_evt[i] = very_low_power_stop_in;
              cnt_d       = '0;
              txf_pop     = txf_valid;
              sh_d        = load_word;
            end
          end
          else if (fall)
          begin
            pins_d.miso = sh_q[dsic_pkg::MSB];
          end
        end
        default:
        begin
          state_d = dsic_pkg::DSIC_IDLE;
        end
      endcase
      // Port one's engine keeps its state, shift word, count and pins while its clock is stopped, so
      // a stop-mode change cannot move its pins behind the frozen engine.
      if ((i == 1) && partial_stop_in)
      begin
        state_d     = state_q;
        sh_d        = sh_q;
        cnt_d       = cnt_q;
        pins_d      = pins_q;
        txf_pop     = 1'b0;
        rxf_push    = 1'b0;
        wake_evt[i] = 1'b0;
      end
      busy_d = (state_d != dsic_pkg::DSIC_IDLE);
      // A received word finds no room when software or DMA fell behind.
      ovr_d  = rxf_push & ~rxf_ready;
    end

    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
      if (!rst_b_in)
      begin
        state_q           <= dsic_pkg::DSIC_IDLE;
        sh_q              <= '0;
        cnt_q             <= '0;
        sclk_prev_q       <= 1'b0;
        pins_q            <= dsic_pkg::PIN_OUT_RST;
        busy_out[i]       <= 1'b0;
        rx_overrun_out[i] <= 1'b0;
      end
      else
      begin
        state_q           <= state_d;
        sh_q              <= sh_d;
        cnt_q             <= cnt_d;
        sclk_prev_q       <= sclk_prev_d;
        pins_q            <= pins_d;
        busy_out[i]       <= busy_d;
        rx_overrun_out[i] <= ovr_d;
      end
    end
  end

  // ****************************************************************
  // Wakeup
  // ****************************************************************
  logic wake_d;

  always_comb
  begin
    wake_d = |wake_evt;
  end

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      wakeup_out <= 1'b0;
    end
    else
    begin
      wakeup_out <= wake_d;
    end
  end

endmodule : dsic_top

`default_nettype wire

// ---- tb/dsic_chk.sv ----
// Concurrent checks on the ports of the dual serial port block.
`timescale 1ns/100ps
`default_nettype none

module dsic_chk (
  input wire logic                          clk_in,
  input wire logic                          rst_b_in,
  input wire logic                          partial_stop_in,
  input wire logic                          very_low_power_stop_in,
  input wire logic [1:0]                    tx_valid_in,
  input wire logic [1:0]                    tx_ready_out,
  input wire logic [1:0]                    rx_valid_out,
  input wire logic [1:0]                    dma_tx_req_out,
  input wire logic [1:0]                    dma_rx_req_out,
  input wire logic [1:0]                    busy_out,
  input wire dsic_pkg::dsic_pin_out_s [1:0] pin_out,
  input wire logic                          wakeup_out
);
  // ****************************************************************
  // Clock rises seen inside one port one frame
  // ****************************************************************
  logic [4:0] rise_q;
  logic [4:0] rise_d;
  logic       sclk_q;

  always_comb
  begin
    rise_d = pin_out[1].ss_b ? 5'h00 : rise_q + 5'(pin_out[1].sclk && !sclk_q);
  end

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      rise_q <= 5'h00;
      sclk_q <= 1'b0;
    end
    else
    begin
      rise_q <= rise_d;
      sclk_q <= pin_out[1].sclk;
    end
  end

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_b_in);

  a_dma_tx_same: assert property (dma_tx_req_out == tx_ready_out)
    else $error("dma tx request differs from tx ready");
  a_dma_rx_same: assert property (dma_rx_req_out == rx_valid_out)
    else $error("dma rx request differs from rx valid");
  a_frame_bits: assert property ($rose(pin_out[1].ss_b) && $past(pin_out[1].ss_b_oe)
    |-> rise_q == 5'h10)
    else $error("port one frame did not carry sixteen clock rises");
  a_single_word: assert property (tx_valid_in[0] && tx_ready_out[0] |=> !tx_ready_out[0])
    else $error("port zero took more than one word");
  a_bus_rate: assert property ($changed(pin_out[0].sclk) |=> $stable(pin_out[0].sclk))
    else $error("port zero clock changed on two clock edges in a row");
  a_stop_freeze: assert property ($past(partial_stop_in) && $past(partial_stop_in, 2)
    && $past(rst_b_in, 2) |-> $stable(pin_out[1]))
    else $error("port one pins moved in partial stop");
  a_slave_only: assert property ((very_low_power_stop_in && busy_out == 2'b00) [*3]
    |-> !pin_out[0].sclk_oe && !pin_out[1].sclk_oe)
    else $error("a port drives its clock in very low power stop");
  a_wake_cause: assert property (wakeup_out |-> $past(very_low_power_stop_in))
    else $error("wakeup outside very low power stop");
  a_wake_pulse: assert property (wakeup_out |=> !wakeup_out)
    else $error("wakeup longer than one cycle");
endmodule : dsic_chk

bind dsic_top dsic_chk u_chk (
  .clk_in                 (clk_in),
  .rst_b_in               (rst_b_in),
  .partial_stop_in        (partial_stop_in),
  .very_low_power_stop_in (very_low_power_stop_in),
  .tx_valid_in            (tx_valid_in),
  .tx_ready_out           (tx_ready_out),
  .rx_valid_out           (rx_valid_out),
  .dma_tx_req_out         (dma_tx_req_out),
  .dma_rx_req_out         (dma_rx_req_out),
  .busy_out               (busy_out),
  .pin_out                (pin_out),
  .wakeup_out             (wakeup_out)
);
`default_nettype wire

// ---- tb/dsic_peer.sv ----
// Behavioural serial peer that answers a master port with counted words.
`timescale 1ns/100ps
`default_nettype none

module dsic_peer (
  input  wire logic        sclk_in,
  input  wire logic        ss_b_in,
  input  wire logic        mosi_in,
  output wire logic        miso_out,
  output var  logic [15:0] got_out
);
  logic [15:0] tx_q   = 16'h0000;
  logic [15:0] sh_q   = 16'h0000;
  logic [7:0]  n_q    = 8'h00;
  logic        last_q = 1'b0;
  logic        ss_prev_q   = 1'b1;
  logic        sclk_prev_q = 1'b0;

  // Counting on the falling select keeps the power-up edge out of the count.
  // One process owns the reply word, so it has a single writer.
  always @(ss_b_in or sclk_in)
  begin
    if (ss_prev_q === 1'b1 && ss_b_in === 1'b0)
    begin
      tx_q = {8'h5A, n_q};
      n_q  = n_q + 8'h01;
    end
    else if (ss_b_in === 1'b0 && sclk_prev_q === 1'b1 && sclk_in === 1'b0)
    begin
      tx_q = {tx_q[14:0], 1'b0};
    end
    ss_prev_q   = ss_b_in;
    sclk_prev_q = sclk_in;
  end
  always @(posedge sclk_in) if (!ss_b_in) sh_q = {sh_q[14:0], mosi_in};
  always @(posedge ss_b_in)
  begin
    last_q  = tx_q[15];
    got_out = sh_q;
  end
  // A released line shows the inverse of its last bit, never a held value.
  assign miso_out = ss_b_in ? ~last_q : tx_q[15];
endmodule : dsic_peer
`default_nettype wire

// ---- tb/tb.sv ----
// Self-checking bench for the dual serial port block.
`timescale 1ns/100ps
`default_nettype none

module tb;
  logic                          clk_in = 1'b0;
  logic                          rst_b_in = 1'b0;
  logic                          partial_stop_in = 1'b0;
  logic                          very_low_power_stop_in = 1'b0;
  logic [1:0]                    master_mode_in = 2'b11;
  logic [1:0]                    tx_valid_in = 2'b00;
  dsic_pkg::dsic_word_t [1:0]    tx_data_in = '0;
  logic [1:0]                    rx_ready_in = 2'b00;
  logic [1:0]                    tx_ready_out;
  logic [1:0]                    rx_valid_out;
  dsic_pkg::dsic_word_t [1:0]    rx_data_out;
  logic [1:0]                    dma_tx_req_out;
  logic [1:0]                    dma_rx_req_out;
  logic [1:0]                    busy_out;
  logic [1:0]                    rx_overrun_out;
  dsic_pkg::dsic_pin_in_s [1:0]  pin_in;
  dsic_pkg::dsic_pin_out_s [1:0] pin_out;
  logic                          wakeup_out;
  logic [1:0]                    m_sclk = 2'b00;
  logic [1:0]                    m_ss_b = 2'b11;
  logic [1:0]                    m_mosi = 2'b00;
  wire logic [1:0]               miso;
  wire logic [1:0][15:0]         got;
  int                            bad_count = 0;
  int                            samples_checked = 0;
  int                            wake_n = 0;
  int                            ovr_n = 0;

  always #25 clk_in = ~clk_in;
  always @(posedge clk_in) if (wakeup_out === 1'b1) wake_n++;
  always @(posedge clk_in) if (rx_overrun_out[0] === 1'b1) ovr_n++;

  dsic_top dut (
    .clk_in                 (clk_in),
    .rst_b_in               (rst_b_in),
    .partial_stop_in        (partial_stop_in),
    .very_low_power_stop_in (very_low_power_stop_in),
    .master_mode_in         (master_mode_in),
    .tx_valid_in            (tx_valid_in),
    .tx_data_in             (tx_data_in),
    .tx_ready_out           (tx_ready_out),
    .rx_valid_out           (rx_valid_out),
    .rx_data_out            (rx_data_out),
    .rx_ready_in            (rx_ready_in),
    .dma_tx_req_out         (dma_tx_req_out),
    .dma_rx_req_out         (dma_rx_req_out),
    .busy_out               (busy_out),
    .rx_overrun_out         (rx_overrun_out),
    .pin_in                 (pin_in),
    .pin_out                (pin_out),
    .wakeup_out             (wakeup_out)
  );

  // Each wire carries whichever party has its enable up.
  always_comb
  begin
    for (int p = 0; p < 2; p++)
    begin
      pin_in[p].sclk = pin_out[p].sclk_oe ? pin_out[p].sclk : m_sclk[p];
      pin_in[p].ss_b = pin_out[p].ss_b_oe ? pin_out[p].ss_b : m_ss_b[p];
      pin_in[p].mosi = pin_out[p].mosi_oe ? pin_out[p].mosi : m_mosi[p];
      pin_in[p].miso = pin_out[p].miso_oe ? pin_out[p].miso : miso[p];
    end
  end

  for (genvar p = 0; p < 2; p++)
  begin : g_peer
    dsic_peer peer (
      .sclk_in  (pin_in[p].sclk),
      .ss_b_in  (pin_in[p].ss_b),
      .mosi_in  (pin_in[p].mosi),
      .miso_out (miso[p]),
      .got_out  (got[p])
    );
  end

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic results;
    if (bad_count == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : results

  task automatic push(input int p, input logic [15:0] w);
    int i;
    i = 0;
    @(posedge clk_in);
    tx_valid_in[p] <= 1'b1;
    tx_data_in[p]  <= w;
    do
    begin
      @(posedge clk_in);
      i++;
    end while (tx_ready_out[p] !== 1'b1 && i < 400);
    if (i >= 400) bad_count++;
    tx_valid_in[p] <= 1'b0;
  endtask : push

  task automatic pop(input int p, input logic [15:0] exp);
    int i;
    i = 0;
    @(posedge clk_in);
    while (rx_valid_out[p] !== 1'b1 && i < 2000)
    begin
      @(posedge clk_in);
      i++;
    end
    if (i >= 2000) bad_count++;
    chk("rx word", rx_data_out[p], exp);
    rx_ready_in[p] <= 1'b1;
    @(posedge clk_in);
    rx_ready_in[p] <= 1'b0;
  endtask : pop

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset;
    chk("tx ready", 16'(tx_ready_out), 16'h0003);
    chk("dma tx", 16'(dma_tx_req_out), 16'h0003);
    chk("dma rx", 16'(dma_rx_req_out), 16'h0000);
  endtask : t_reset

  // Partial stop holds port one, so its queue fills with nothing draining it.
  task automatic t_fill;
    int n;
    n = 0;
    @(posedge clk_in);
    partial_stop_in <= 1'b1;
    tx_valid_in[1]  <= 1'b1;
    tx_data_in[1]   <= 16'h1000;
    repeat (12)
    begin
      @(posedge clk_in);
      if (tx_ready_out[1] === 1'b1)
      begin
        n++;
        tx_data_in[1] <= 16'h1000 + 16'(n);
      end
    end
    tx_valid_in[1] <= 1'b0;
    chk("port one accepted", 16'(n), 16'h0004);
    chk("port one busy", 16'(busy_out[1]), 16'h0000);
    chk("port one select", 16'(pin_out[1].ss_b), 16'h0001);
    partial_stop_in <= 1'b0;
    for (int k = 0; k < 4; k++) pop(1, 16'h5A00 + 16'(k));
    chk("peer word", got[1], 16'h1003);
  endtask : t_fill

  task automatic t_rate;
    int hi [2];
    for (int p = 0; p < 2; p++)
    begin
      push(p, 16'h8001);
      hi[p] = 0;
      for (int i = 0; i < 99 && pin_out[p].sclk !== 1'b1; i++) @(posedge clk_in);
      while (pin_out[p].sclk === 1'b1 && hi[p] < 99)
      begin
        @(posedge clk_in);
        hi[p]++;
      end
      pop(p, p ? 16'h5A04 : 16'h5A00);
    end
    chk("port zero half period", 16'(hi[0]), 16'(dsic_pkg::BUS_DIV_LAST) + 16'h0001);
    chk("port one half period", 16'(hi[1]), 16'h0001);
  endtask : t_rate

  task automatic t_slave;
    logic [15:0] seen;
    logic [15:0] w;
    w = 16'h9B6E;
    @(posedge clk_in);
    very_low_power_stop_in <= 1'b1;
    repeat (4) @(posedge clk_in);
    chk("slave clock enable", 16'(pin_out[0].sclk_oe), 16'h0000);
    push(0, 16'hC3A5);
    m_ss_b[0] <= 1'b0;
    for (int b = 15; b >= 0; b--)
    begin
      m_mosi[0] <= w[b];
      repeat (4) @(posedge clk_in);
      m_sclk[0] <= 1'b1;
      seen[b] = pin_in[0].miso;
      repeat (4) @(posedge clk_in);
      m_sclk[0] <= 1'b0;
    end
    repeat (4) @(posedge clk_in);
    m_ss_b[0] <= 1'b1;
    chk("slave reply", seen, 16'hC3A5);
    chk("wakeups", 16'(wake_n), 16'h0001);
    very_low_power_stop_in <= 1'b0;
    pop(0, w);
  endtask : t_slave

  // Two words into port zero with nobody reading: the second finds no room.
  task automatic t_overrun;
    push(0, 16'h0F0F);
    push(0, 16'hF0F0);
    repeat (200) @(posedge clk_in);
    chk("overruns", 16'(ovr_n), 16'h0001);
    pop(0, 16'h5A02);
    chk("peer word zero", got[0], 16'hF0F0);
  endtask : t_overrun

  initial
  begin
    repeat (6) @(posedge clk_in);
    rst_b_in <= 1'b1;
    @(posedge clk_in);
    t_reset();
    t_fill();
    t_rate();
    t_slave();
    t_overrun();
    results();
  end

  // The whole sequence needs well under a thousand cycles; this allows twenty thousand.
  initial
  begin
    #1000000;
    bad_count++;
    results();
  end
endmodule : tb
`default_nettype wire
